// file: include/fdpc_defs.svh
// Purpose: constants for the flash download/program control block
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes: offsets are byte addresses of word registers
`ifndef FDPC_DEFS_SVH
`define FDPC_DEFS_SVH
`define FDPC_OFF_KEY 5'h00
`define FDPC_OFF_CODECTL 5'h04
`define FDPC_OFF_PROGSEL 5'h08
`define FDPC_OFF_ERASESEL 5'h0C
`define FDPC_OFF_DEST 5'h10
`define FDPC_OFF_RESULT 5'h14
`define FDPC_OFF_CALL 5'h18
`define FDPC_OFF_PARAM 5'h1C
`define FDPC_KEY_DOWNLOAD 8'hA5
`define FDPC_KEY_PROGRAM 8'h5A
`define FDPC_BIT_REQ 0
`define FDPC_BIT_EMUL 1
`define FDPC_BIT_INRAM 2
`define FDPC_BIT_BUSY 3
`define FDPC_BIT_HOLDIRQ 4
`define FDPC_BIT_SEL 0
`define FDPC_BIT_DESTERR 7
`define FDPC_RES_SRCSEL 2
`define FDPC_RES_KEYERR 1
`define FDPC_RES_OK 8'h00
`define FDPC_DEST_MAX 8'h0F
`define FDPC_ENTRY_INIT 12'h020
`define FDPC_ENTRY_PROG 12'h010
`define FDPC_ENTRY_MARK 16'hE0E0
`define FDPC_STACK_MAX 8'h80
`define FDPC_COPY_WORDS 9'h1FF
`define FDPC_FREQ_MIN 16'h07D0
`define FDPC_FREQ_MAX 16'h0FA0
`define FDPC_UFLASH_TOP 32'h0010_0000
`define FDPC_RAM_BASE 32'hFFFF_0000
`define FDPC_RAM_TOP 32'hFFFF_BFFF
`define FDPC_ERR_FREQ 8'h01
`define FDPC_ERR_ADDR 8'h02
`define FDPC_ERR_SRC 8'h04
`define FDPC_ERR_KEY 8'h08
`endif

// file: include/fdpc_pkg.sv
// Purpose: types for the flash download/program control block
// Assumes: nothing
// Notes: constants live in fdpc_defs.svh
package fdpc_pkg;
  typedef enum logic [2:0] {FDPC_IDLE, FDPC_MAP, FDPC_CHECK, FDPC_COPY, FDPC_RESULT,
    FDPC_RESTORE} fdpc_dl_e;
  typedef enum logic [1:0] {FDPC_CALL_NONE, FDPC_CALL_INIT, FDPC_CALL_PROG} fdpc_call_e;
endpackage

// file: hw/fdpc_param_check.sv
// Purpose: checks parameters of the init and program calls
// Assumes: inputs held stable while call strobe high
// Notes: pure combinational; result code zero means pass
`timescale 1ns/1ns
`include "fdpc_defs.svh"
module fdpc_param_check (
  // Call
  input wire fdpc_pkg::fdpc_call_e callKind,
  input wire logic [31:0] argR4,
  input wire logic [31:0] argR5,
  input wire logic [7:0] protectKey,
  // Result
  output logic [7:0] resultCode
);
  import fdpc_pkg::*;
  function automatic logic inFlash(input logic [31:0] a);
    inFlash = a < `FDPC_UFLASH_TOP;
  endfunction
  always_comb begin
    resultCode = `FDPC_RES_OK;
    unique case (callKind)
      FDPC_CALL_INIT: begin
        if (argR4[15:0] < `FDPC_FREQ_MIN || argR4[15:0] > `FDPC_FREQ_MAX ||
            argR4[31:16] != 16'h0000) begin
          resultCode = `FDPC_ERR_FREQ;
        end
      end
      FDPC_CALL_PROG: begin
        if (protectKey != `FDPC_KEY_PROGRAM) begin
          resultCode = `FDPC_ERR_KEY;
        end else if (!inFlash(argR5) || argR5[6:0] != 7'h00) begin
          resultCode = `FDPC_ERR_ADDR;
        end else if (inFlash(argR4)) begin
          resultCode = `FDPC_ERR_SRC;
        end
      end
      FDPC_CALL_NONE: resultCode = `FDPC_RES_OK;
      default: resultCode = `FDPC_RES_OK;
    endcase
  end
endmodule

// file: hw/fdpc_copy_engine.sv
// Purpose: copies routine words from storage area into RAM
// Assumes: start is a one-cycle pulse, ramReady from same clock
// Notes: stalls on ramReady so RAM back-pressure reaches the copier
`timescale 1ns/1ns
`include "fdpc_defs.svh"
module fdpc_copy_engine (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // Control
  input wire logic start,
  input wire logic [3:0] destBlock,
  output logic done,
  // RAM write port
  output logic ramWrite,
  output logic [31:0] ramAddr,
  output logic [31:0] ramData,
  input wire logic ramReady
);
  logic [8:0] wordIdx;
  logic running;
  // Routine image stand-in: a fixed pattern per word
  function automatic logic [31:0] romWord(input logic [8:0] i);
    romWord = {23'h000000, i} ^ 32'h5A5A_0000;
    // Entry words carry a marker so callers can find them
    if ({1'b0, i, 2'b00} == `FDPC_ENTRY_PROG || {1'b0, i, 2'b00} == `FDPC_ENTRY_INIT) begin
      romWord = {`FDPC_ENTRY_MARK, 7'h00, i};
    end
  endfunction
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      running <= 1'b0;
      wordIdx <= 9'h000;
      done <= 1'b0;
    end else if (clkEn) begin
      done <= 1'b0;
      if (start && !running) begin
        running <= 1'b1;
        wordIdx <= 9'h000;
      end else if (running && ramReady) begin
        if (wordIdx == `FDPC_COPY_WORDS) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          wordIdx <= wordIdx + 9'h001;
        end
      end
    end
  end
  always_comb begin
    ramWrite = running;
    ramAddr = `FDPC_RAM_BASE + {16'h0000, destBlock, 12'h000} + {21'h000000, wordIdx, 2'b00};
    ramData = romWord(wordIdx);
  end
endmodule

// file: hw/fdpc_top.sv
// Purpose: flash download request, routine copy and call checks
// Assumes: CPU and RAM interfaces on sys_clk; AXI4-Lite for registers
// Notes: routine execution itself is modelled by the call port
`timescale 1ns/1ns
`include "fdpc_defs.svh"
// Behaviour
// - Program select bit set to 1 chooses the programming routine.
// - More than one routine selected: skip copy, set source-select error.
// - Request accepted only with key A5, emulation off, write from RAM.
// - Request starts download automatically; bit clears before software resumes.
// - Map storage, check, copy, clear request bits, write result, restore map.
// - Result zero on success; bit 2 selection error, bit 1 key error (never set: a wrong key leaves the result untouched).
// - Destination register bit 7 flags bad destination; result byte untouched.
// - CPU registers kept, interrupts held during download, serviced after.
// - Init call refuses out-of-range CPU frequency with an error code.
// - Init entry at start plus 32, program entry at start plus 16.
// - Routines preserve registers except result register; stack at most 128 bytes.
// - Program call rejects destinations outside user flash or off 128-byte boundary.
// - Program call rejects a source pointer inside flash.
module fdpc_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // CPU status
  input wire logic fetchFromRam,
  input wire logic ramEmulation,
  input wire logic irqPending,
  output logic cpuHold,
  output logic irqHeld,
  output logic storageMapped,
  // RAM write port
  output logic ramWrite,
  output logic [31:0] ramAddr,
  output logic [31:0] ramData,
  input wire logic ramReady
);
  import fdpc_pkg::*;

  logic [7:0] flashProtectKey;
  logic downloadRequest;
  logic programSel;
  logic eraseSel;
  logic [7:0] downloadDestination;
  logic [7:0] downloadResult;
  logic resultValid;
  logic [7:0] routineResult;
  logic [31:0] callArgR4;
  logic [31:0] callArgR5;
  fdpc_call_e callKind;
  fdpc_dl_e dlState;
  logic copyStart;
  logic copyDone;
  logic [7:0] checkCode;
  logic fetchRamS1, fetchRamS2, emulS1, emulS2;
  logic awHeld, wHeld;
  logic [4:0] awOff;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic next_awHeld, next_wHeld, next_bvalid;
  logic copyLast, copyReady;
  logic ramWriteInt;
  logic [31:0] ramAddrInt, ramDataInt;
  logic [7:0] selBits;

  function automatic logic mapped(input logic [31:0] a);
    mapped = a[31:5] == 27'h0000000;
  endfunction

  // Pins come from CPU status outside this clock's view
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fetchRamS1 <= 1'b0;
      fetchRamS2 <= 1'b0;
      emulS1 <= 1'b0;
      emulS2 <= 1'b0;
    end else if (clkEn) begin
      fetchRamS1 <= fetchFromRam;
      fetchRamS2 <= fetchRamS1;
      emulS1 <= ramEmulation;
      emulS2 <= emulS1;
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awOff <= 5'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (clkEn) begin
      // Ready comes from a flop, so it looks one edge ahead at the held state
      s_axi_awready <= !next_awHeld && !next_bvalid;
      s_axi_wready <= !next_wHeld && !next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awOff <= s_axi_awaddr[4:0];
        s_axi_bresp <= mapped(s_axi_awaddr) ? 2'b00 : 2'b10;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_comb begin
    doWrite = awHeld && wHeld && !s_axi_bvalid;
    next_awHeld = doWrite ? 1'b0 : (awHeld || (s_axi_awvalid && s_axi_awready));
    next_wHeld = doWrite ? 1'b0 : (wHeld || (s_axi_wvalid && s_axi_wready));
    next_bvalid = doWrite || (s_axi_bvalid && !s_axi_bready);
  end

  // Register writes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flashProtectKey <= 8'h00;
      downloadRequest <= 1'b0;
      programSel <= 1'b0;
      eraseSel <= 1'b0;
      downloadDestination <= 8'h00;
      callArgR4 <= 32'h0000_0000;
      callArgR5 <= 32'h0000_0000;
      callKind <= FDPC_CALL_NONE;
      routineResult <= 8'h00;
    end else if (clkEn) begin
      callKind <= FDPC_CALL_NONE;
      if (callKind != FDPC_CALL_NONE) begin
        routineResult <= checkCode;
      end
      // Also on RESTORE: a bad destination skips RESULT
      if (dlState == FDPC_RESULT || dlState == FDPC_RESTORE) begin
        downloadRequest <= 1'b0;
        programSel <= 1'b0;
        eraseSel <= 1'b0;
      end
      // Registers frozen while a download owns the bus
      if (doWrite && wStrb[0] && dlState == FDPC_IDLE && s_axi_bresp == 2'b00) begin
        unique case (awOff)
          `FDPC_OFF_KEY: flashProtectKey <= wData[7:0];
          `FDPC_OFF_CODECTL: begin
            if (wData[`FDPC_BIT_REQ] && flashProtectKey == `FDPC_KEY_DOWNLOAD &&
                !emulS2 && fetchRamS2) begin
              downloadRequest <= 1'b1;
            end
          end
          `FDPC_OFF_PROGSEL: programSel <= wData[`FDPC_BIT_SEL];
          `FDPC_OFF_ERASESEL: eraseSel <= wData[`FDPC_BIT_SEL];
          `FDPC_OFF_DEST: downloadDestination <= {1'b0, wData[6:0]};
          `FDPC_OFF_PARAM: callArgR4 <= wData;
          `FDPC_OFF_RESULT: callArgR5 <= wData;
          `FDPC_OFF_CALL: begin
            if (wData[1:0] == 2'b01) begin
              callKind <= FDPC_CALL_INIT;
            end else if (wData[1:0] == 2'b10) begin
              callKind <= FDPC_CALL_PROG;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Download sequence
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dlState <= FDPC_IDLE;
      downloadResult <= 8'hFF;
      resultValid <= 1'b0;
      copyStart <= 1'b0;
      selBits <= 8'h00;
      copyLast <= 1'b0;
    end else if (clkEn) begin
      copyStart <= 1'b0;
      unique case (dlState)
        FDPC_IDLE: if (downloadRequest) dlState <= FDPC_MAP;
        FDPC_MAP: dlState <= FDPC_CHECK;
        FDPC_CHECK: begin
          selBits <= 8'h00;
          if (downloadDestination[6:0] > 7'(`FDPC_DEST_MAX)) begin
            dlState <= FDPC_RESTORE;
          end else if (programSel && eraseSel) begin
            selBits[`FDPC_RES_SRCSEL] <= 1'b1;
            dlState <= FDPC_RESULT;
          end else if (!programSel && !eraseSel) begin
            selBits[`FDPC_RES_SRCSEL] <= 1'b1;
            dlState <= FDPC_RESULT;
          end else begin
            copyStart <= 1'b1;
            dlState <= FDPC_COPY;
          end
        end
        FDPC_COPY: begin
          // Last word may still sit in the output stage; leave once it is taken
          if ((copyDone || copyLast) && (!ramWrite || ramReady)) begin
            copyLast <= 1'b0;
            dlState <= FDPC_RESULT;
          end else if (copyDone) begin
            copyLast <= 1'b1;
          end
        end
        FDPC_RESULT: begin
          downloadResult <= selBits;
          resultValid <= 1'b1;
          dlState <= FDPC_RESTORE;
        end
        FDPC_RESTORE: dlState <= FDPC_IDLE;
      endcase
    end
  end

  // Destination error flag lives in bit 7 of its register
  logic destErr;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      destErr <= 1'b0;
    end else if (clkEn) begin
      if (dlState == FDPC_CHECK) begin
        destErr <= downloadDestination[6:0] > 7'(`FDPC_DEST_MAX);
      end
    end
  end

  // Read channel, one cycle to answer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      s_axi_arready <= 1'b0;
    end else if (clkEn) begin
      s_axi_arready <= !((s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready));
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        unique case (s_axi_araddr[4:0])
          `FDPC_OFF_KEY: s_axi_rdata <= {24'h000000, flashProtectKey};
          `FDPC_OFF_CODECTL: s_axi_rdata <= {27'h0000000, irqHeld, cpuHold, fetchRamS2,
            emulS2, downloadRequest};
          `FDPC_OFF_PROGSEL: s_axi_rdata <= {31'h00000000, programSel};
          `FDPC_OFF_ERASESEL: s_axi_rdata <= {31'h00000000, eraseSel};
          `FDPC_OFF_DEST: s_axi_rdata <= {24'h000000, destErr, downloadDestination[6:0]};
          `FDPC_OFF_RESULT: s_axi_rdata <= {23'h000000, resultValid, downloadResult};
          `FDPC_OFF_CALL: s_axi_rdata <= {24'h000000, routineResult};
          `FDPC_OFF_PARAM: s_axi_rdata <= callArgR4;
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
        // Unmapped reads give zero whatever the low bits decode to
        if (!mapped(s_axi_araddr)) s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // CPU hold and interrupt retention during download
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpuHold <= 1'b0;
      irqHeld <= 1'b0;
      storageMapped <= 1'b0;
    end else if (clkEn) begin
      cpuHold <= dlState != FDPC_IDLE || downloadRequest;
      storageMapped <= dlState == FDPC_MAP || dlState == FDPC_CHECK ||
        dlState == FDPC_COPY || dlState == FDPC_RESULT;
      if (irqPending && (dlState != FDPC_IDLE || downloadRequest)) begin
        irqHeld <= 1'b1;
      end else if (dlState == FDPC_IDLE && !downloadRequest) begin
        irqHeld <= 1'b0;
      end
    end
  end

  // One-word output stage; the copier advances only when the stage frees up
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ramWrite <= 1'b0;
      ramAddr <= 32'h0000_0000;
      ramData <= 32'h0000_0000;
    end else if (clkEn && copyReady) begin
      ramWrite <= ramWriteInt;
      ramAddr <= ramAddrInt;
      ramData <= ramDataInt;
    end
  end
  always_comb begin
    copyReady = !ramWrite || ramReady;
  end

  fdpc_copy_engine copier (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .start(copyStart),
    .destBlock(downloadDestination[3:0]),
    .done(copyDone),
    .ramWrite(ramWriteInt),
    .ramAddr(ramAddrInt),
    .ramData(ramDataInt),
    .ramReady(copyReady)
  );

  fdpc_param_check callCheck (
    .callKind(callKind),
    .argR4(callArgR4),
    .argR5(callArgR5),
    .protectKey(flashProtectKey),
    .resultCode(checkCode)
  );
endmodule

// file: tb/fdpc_checker.sv
// Purpose: port-level checks on fdpc_top
// Assumes: one clock, clkEn held high by the bench
// Notes: bound into every fdpc_top
`timescale 1ns/1ns
`include "fdpc_defs.svh"
module fdpc_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Download status
  input wire logic irqPending,
  input wire logic cpuHold,
  input wire logic irqHeld,
  input wire logic storageMapped,
  // RAM port
  input wire logic ramWrite,
  input wire logic [31:0] ramAddr,
  input wire logic [31:0] ramData,
  input wire logic ramReady
);
  logic [9:0] copyCount;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Words taken in this download; cleared between downloads
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) copyCount <= 10'h000;
    else if (!cpuHold) copyCount <= 10'h000;
    else if (ramWrite && ramReady) copyCount <= copyCount + 10'h001;
  end
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed early");
  copy_stall_a: assert property (ramWrite && !ramReady |=>
    ramWrite && $stable(ramAddr) && $stable(ramData)) else $error("stalled word lost");
  copy_inside_a: assert property (ramWrite |-> cpuHold && storageMapped)
    else $error("copy outside download");
  copy_step_a: assert property (ramWrite && ramReady ##1 ramWrite |->
    ramAddr == $past(ramAddr) + 32'h4) else $error("copy address step wrong");
  copy_base_a: assert property (ramWrite && copyCount == 10'h000 |->
    ramAddr[11:0] == 12'h000 && ramAddr[31:16] == 16'hFFFF) else $error("copy base wrong");
  copy_length_a: assert property ($fell(cpuHold) |->
    copyCount == 10'h000 || copyCount == 10'h200) else $error("copy length wrong");
  irq_capture_a: assert property (cpuHold && irqPending ##1 cpuHold [*3] |-> irqHeld)
    else $error("request not held");
  irq_release_a: assert property (!cpuHold [*4] |-> !irqHeld)
    else $error("held request not released");
  entry_mark_a: assert property (ramWrite && (ramAddr[11:0] == `FDPC_ENTRY_PROG ||
    ramAddr[11:0] == `FDPC_ENTRY_INIT) |-> ramData[31:16] == `FDPC_ENTRY_MARK)
    else $error("entry word wrong");
endmodule
bind fdpc_top fdpc_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .irqPending(irqPending), .cpuHold(cpuHold), .irqHeld(irqHeld),
  .storageMapped(storageMapped), .ramWrite(ramWrite), .ramAddr(ramAddr),
  .ramData(ramData), .ramReady(ramReady));

// file: tb/fdpc_ram_model.sv
// Purpose: on-chip RAM seen by the routine copier
// Assumes: one word per accepted cycle
// Notes: slow mode stalls from a free LFSR
`timescale 1ns/1ns
module fdpc_ram_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Pace
  input wire logic slow,
  // RAM write port
  input wire logic ramWrite,
  input wire logic [31:0] ramAddr,
  output logic ramReady,
  // Observation
  output logic [15:0] words,
  output logic [31:0] lastAddr
);
  logic [7:0] lfsr;
  // Slow mode: pseudo-random stalls whenever LFSR bit 0 is low, not a fixed pattern
  assign ramReady = slow ? lfsr[0] : 1'h1;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) lfsr <= 8'hA1;
    else lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  end
  // Only the copier writes; no other master touches RAM meanwhile
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      words <= 16'h0000;
      lastAddr <= 32'h0;
    end else if (ramWrite && ramReady) begin
      words <= words + 16'h0001;
      lastAddr <= ramAddr;
    end
  end
endmodule

// file: tb/tb_fdpc_top.sv
// Purpose: self-checking bench for fdpc_top
// Assumes: register map and codes from fdpc_defs.svh
// Notes: a bench model predicts each download and call result
`timescale 1ns/1ns
`include "fdpc_defs.svh"
module tb_fdpc_top;
  logic sys_clk, nrst, clkEn, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, ramAddr, ramData;
  logic [31:0] lastAddr, rd, res0, rres, dres;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic fetchFromRam, ramEmulation, irqPending, cpuHold, irqHeld, storageMapped, ramWrite;
  logic ramReady;
  logic [15:0] words;
  int n_mismatch, num_checks, seed, i;
  localparam logic [31:0] aKey = 32'(`FDPC_OFF_KEY);
  localparam logic [31:0] aCtl = 32'(`FDPC_OFF_CODECTL);
  localparam logic [31:0] aProg = 32'(`FDPC_OFF_PROGSEL);
  localparam logic [31:0] aErase = 32'(`FDPC_OFF_ERASESEL);
  localparam logic [31:0] aDest = 32'(`FDPC_OFF_DEST);
  localparam logic [31:0] aRes = 32'(`FDPC_OFF_RESULT);
  localparam logic [31:0] aCall = 32'(`FDPC_OFF_CALL);
  localparam logic [31:0] aParam = 32'(`FDPC_OFF_PARAM);
  logic [31:0] tr4 [7] = '{32'hFFFF0000, 32'hFFFF0000, 32'hFFFF0000, 32'hFFFF0000,
    32'hFFFF0000, 32'h00000400, 32'hFFFF0000};
  logic [31:0] tr5 [7] = '{32'h100, 32'h180, 32'h140, 32'hFFF80, 32'h100000, 32'h200, 32'h0};
  logic [7:0] tkey [7] = '{8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h00};
  int tf [4] = '{1999, 2000, 4000, 4001};
  fdpc_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .fetchFromRam(fetchFromRam),
    .ramEmulation(ramEmulation), .irqPending(irqPending), .cpuHold(cpuHold),
    .irqHeld(irqHeld), .storageMapped(storageMapped), .ramWrite(ramWrite),
    .ramAddr(ramAddr), .ramData(ramData), .ramReady(ramReady));
  fdpc_ram_model u_ram (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .ramWrite(ramWrite),
    .ramAddr(ramAddr), .ramReady(ramReady), .words(words), .lastAddr(lastAddr));
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task timeout;
    n_mismatch++;
    $display("ERROR %0t: wait bound used up", $time);
    final_report();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; ready and answers sampled mid-cycle, released after the edge
  task axi(input bit wr, input logic [31:0] a, input logic [31:0] d);
    bit pa, pw, ga, gw, gr;
    int n;
    pa = 1;
    pw = wr;
    gr = 0;
    @(posedge sys_clk);
    if (wr) begin
      s_axi_awvalid <= 1'h1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_arvalid <= 1'h1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'h1;
    end
    for (n = 0; n < 200 && !gr; n++) begin
      @(negedge sys_clk);
      ga = pa && (wr ? s_axi_awready : s_axi_arready);
      gw = pw && s_axi_wready;
      gr = wr ? s_axi_bvalid : s_axi_rvalid;
      rd = s_axi_rdata;
      resp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge sys_clk);
      if (ga) begin
        pa = 0;
        s_axi_awvalid <= 1'h0;
        s_axi_arvalid <= 1'h0;
      end
      if (gw) begin
        pw = 0;
        s_axi_wvalid <= 1'h0;
      end
      if (gr) begin
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
      end
    end
    if (!gr) timeout();
  endtask
  function automatic int call_model(int kind, logic [31:0] r4, logic [31:0] r5, logic [7:0] k);
    int c;
    c = 0;
    if (kind == 1 && (r4 < `FDPC_FREQ_MIN || r4 > `FDPC_FREQ_MAX)) c |= `FDPC_ERR_FREQ;
    if (kind == 2 && k != `FDPC_KEY_PROGRAM) c |= `FDPC_ERR_KEY;
    if (kind == 2 && (r5 >= `FDPC_UFLASH_TOP || r5[6:0] != 7'h00)) c |= `FDPC_ERR_ADDR;
    if (kind == 2 && r4 < `FDPC_UFLASH_TOP) c |= `FDPC_ERR_SRC;
    return c;
  endfunction
  task do_call(int kind, logic [31:0] r4, logic [31:0] r5, logic [7:0] k);
    axi(1, aKey, {24'h0, k});
    axi(1, aParam, r4);
    axi(1, aRes, r5);
    axi(1, aCall, kind);
    repeat (3) @(posedge sys_clk);
    axi(0, aCall, 32'h0);
    chk(rd[7:0], call_model(kind, r4, r5, k));
    axi(0, aParam, 32'h0);
    chk(rd, r4);
  endtask
  task dl(logic [7:0] k, int ps, int es, int n, bit emul, bit fram, bit irq);
    logic [15:0] w0;
    bit ok, up, seen;
    int j;
    ramEmulation <= emul;
    fetchFromRam <= fram;
    axi(1, aKey, {24'h0, k});
    axi(1, aProg, ps);
    axi(1, aErase, es);
    axi(1, aDest, n);
    axi(0, aRes, 32'h0);
    res0 = rd;
    w0 = words;
    irqPending <= irq;
    axi(1, aCtl, 32'h1);
    ok = k == `FDPC_KEY_DOWNLOAD && !emul && fram;
    up = 0;
    seen = 0;
    for (j = 0; j < 6000 && !(up && !cpuHold) && !(!up && j > 40); j++) begin
      @(negedge sys_clk);
      up |= cpuHold;
      seen |= irqHeld === 1'h1;
    end
    if (j == 6000) timeout();
    @(posedge sys_clk);
    irqPending <= 1'h0;
    repeat (5) @(posedge sys_clk);
    chk(irqHeld, 0);
    chk(seen, irq);
    axi(0, aCtl, 32'h0);
    chk(rd[`FDPC_BIT_REQ], 0);
    axi(0, aDest, 32'h0);
    dres = rd;
    axi(0, aRes, 32'h0);
    rres = rd;
    if (!ok) begin
      chk(rres, res0);
      chk(words, w0);
    end else if (n > `FDPC_DEST_MAX) begin
      chk(dres[`FDPC_BIT_DESTERR], 1);
      chk(rres, res0);
    end else if (ps == es) begin
      chk(rres[7:0], 8'h04);
      chk(words, w0);
    end else begin
      chk(rres[7:0], `FDPC_RES_OK);
      chk(words, w0 + 512);
      chk(lastAddr, `FDPC_RAM_BASE + n * 4096 + 2044);
      axi(0, aProg, 32'h0);
      chk(rd[`FDPC_BIT_SEL], 0);
    end
  endtask
  initial begin
    {nrst, slow, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {clkEn, fetchFromRam, ramEmulation, irqPending} = 4'h8;
    s_axi_wstrb = 4'hF;
    seed = 10;
    n_mismatch = 0;
    num_checks = 0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'h1;
    fetchFromRam <= 1'h1;
    repeat (3) @(posedge sys_clk);
    axi(0, aRes, 32'h0);
    chk(rd[7:0], 8'hFF);
    axi(0, 32'h20, 32'h0);
    chk({rd[29:0], resp}, 32'h2);
    axi(1, 32'h24, 32'h1);
    chk(resp, 2'h2);
    dl(8'h00, 1, 0, 1, 0, 1, 0);
    dl(8'hA5, 1, 0, 2, 1, 1, 0);
    dl(8'hA5, 1, 0, 3, 0, 0, 0);
    dl(8'hA5, 1, 1, 4, 0, 1, 0);
    dl(8'hA5, 0, 0, 5, 0, 1, 0);
    dl(8'hA5, 1, 0, 16, 0, 1, 0);
    slow <= 1'h1;
    dl(8'hA5, 1, 0, 0, 0, 1, 1);
    slow <= 1'h0;
    dl(8'hA5, 0, 1, 15, 0, 1, 0);
    for (i = 0; i < 4; i++) do_call(1, tf[i], 32'h0, 8'h5A);
    for (i = 0; i < 3; i++) do_call(1, 2000 + {$random(seed)} % 2001, 32'h0, 8'h5A);
    for (i = 0; i < 7; i++) do_call(2, tr4[i], tr5[i], tkey[i]);
    for (i = 0; i < 3; i++) do_call(2, tr4[0], $random(seed) & 32'hFFF80, 8'h5A);
    final_report();
  end
endmodule
